// ---- common/iab_pkg.sv ----
// Package for the instruction address breakpoint unit: layout, numbers and carriers
package iab_pkg;

	// Special register number of the breakpoint register (1010)
	localparam logic [9:0] IAB_SREG_NUM = 10'h3f2;
	localparam int IAB_SREG_NUM_W = 10;
	localparam int IAB_DATA_W = 32;

	// Field positions; register bit 0 is the MSB, so bits 0..29 sit at [31:2]
	localparam int IAB_ADDR_MSB = 31;
	localparam int IAB_ADDR_LSB = 2;
	localparam int IAB_CHECK_ON_POS = 1;
	localparam int IAB_XLATE_POS = 0;

	// Reset value: breakpoint off, nothing stored
	localparam logic [31:0] IAB_REG_RESET = 32'h0000_0000;

	// Exception vector offset of the instruction address breakpoint
	localparam logic [31:0] IAB_EXC_VECTOR = 32'h0000_1300;

	// Move-to / move-from special register request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [9:0] num;
		logic [31:0] wdata;
	} iab_sreg_req_t;

	// One instruction fetch as seen by the comparator
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic machine_state_instr_translate;
	} iab_fetch_t;

	// Word compare: the two lowest address bits never take part
	function automatic logic iab_word_match(input logic [31:0] a, input logic [31:0] b);
		return a[IAB_ADDR_MSB:IAB_ADDR_LSB] == b[IAB_ADDR_MSB:IAB_ADDR_LSB];
	endfunction : iab_word_match

	// Decode of the special register number
	function automatic logic iab_sreg_hit(input logic [9:0] num);
		return num == IAB_SREG_NUM;
	endfunction : iab_sreg_hit

endpackage : iab_pkg

// ---- design/iab_compare.sv ----
// Fetch address comparator for the instruction address breakpoint
`timescale 1ns/1ps
module iab_compare import iab_pkg::*; (
	// Stored breakpoint register
	input wire logic [31:0] bp_reg_i,
	// Current fetch
	input wire iab_fetch_t fetch_i,
	// Match result
	output logic hit_o
);

	logic check_on;
	logic xlate_ok;
	logic word_ok;

	// Field extraction
	assign check_on = bp_reg_i[IAB_CHECK_ON_POS];
	assign xlate_ok = bp_reg_i[IAB_XLATE_POS] == fetch_i.machine_state_instr_translate;
	assign word_ok = iab_word_match(fetch_i.addr, bp_reg_i);

	// gated compare; enable off means no hit at all
	assign hit_o = fetch_i.valid && check_on && word_ok && xlate_ok;

endmodule : iab_compare

// ---- design/iab_breakpoint.sv ----
// Instruction address breakpoint unit: special register and fetch match exception
`timescale 1ns/1ps
module iab_breakpoint import iab_pkg::*; (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	// Special register access
	input wire iab_sreg_req_t SREG_REQ_I,
	input wire logic SUPERVISOR_I,
	output logic [31:0] SREG_RDATA_O,
	output logic SREG_RD_VALID_O,
	output logic SREG_PRIV_FAULT_O,
	// Instruction fetch
	input wire iab_fetch_t FETCH_I,
	// Exception request to the core
	output logic BKPT_EXC_O,
	output logic [31:0] BKPT_VECTOR_O,
	output logic [31:0] BKPT_ADDR_O
);

	logic [31:0] bp_reg;
	logic [31:0] bp_next;
	logic hit;
	logic sreg_sel;
	logic sup_wr;
	logic sup_rd;
	logic [31:0] rdata_reg;
	logic rd_valid_reg;
	logic priv_fault_reg;
	logic exc_reg;
	logic [31:0] vector_reg;
	logic [31:0] addr_reg;

	// Access decode; user-mode access to this number is refused
	assign sreg_sel = iab_sreg_hit(SREG_REQ_I.num);
	assign sup_wr = SREG_REQ_I.wr && sreg_sel && SUPERVISOR_I;
	assign sup_rd = SREG_REQ_I.rd && sreg_sel && SUPERVISOR_I;

	// Next register value
	always_comb begin
		bp_next = bp_reg;
		if (sup_wr) begin
			bp_next = SREG_REQ_I.wdata;
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			bp_reg <= IAB_REG_RESET;
		end else begin
			bp_reg <= bp_next;
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_reg <= 32'h0000_0000;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= sup_rd;
			if (sup_rd) begin
				rdata_reg <= bp_reg;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			priv_fault_reg <= 1'b0;
		end else begin
			priv_fault_reg <= (SREG_REQ_I.wr || SREG_REQ_I.rd) && sreg_sel && !SUPERVISOR_I;
		end
	end

	// Compare uses the value held before a same-cycle write
	iab_compare u_compare (
		.bp_reg_i(bp_reg),
		.fetch_i(FETCH_I),
		.hit_o(hit)
	);

	// exception flagged one cycle after the fetch, ahead of execution
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			exc_reg <= 1'b0;
			vector_reg <= 32'h0000_0000;
			addr_reg <= 32'h0000_0000;
		end else begin
			exc_reg <= hit;
			if (hit) begin
				vector_reg <= IAB_EXC_VECTOR;
				addr_reg <= FETCH_I.addr; // Instruction to be suppressed
			end
		end
	end

	// Outputs straight from flops
	assign SREG_RDATA_O = rdata_reg;
	assign SREG_RD_VALID_O = rd_valid_reg;
	assign SREG_PRIV_FAULT_O = priv_fault_reg;
	assign BKPT_EXC_O = exc_reg;
	assign BKPT_VECTOR_O = vector_reg;
	assign BKPT_ADDR_O = addr_reg;

	// Checks on the fetch compare
	property p_hit_fires;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(FETCH_I.valid && bp_reg[IAB_CHECK_ON_POS]
			&& FETCH_I.addr[31:2] == bp_reg[31:2]
			&& FETCH_I.machine_state_instr_translate == bp_reg[IAB_XLATE_POS])
		|=> BKPT_EXC_O;
	endproperty
	a_hit_fires: assert property (p_hit_fires) else $error("match gave no exception");

	property p_word_only;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		BKPT_EXC_O |-> ($past(FETCH_I.addr[31:2]) == $past(bp_reg[31:2]) && $past(FETCH_I.valid));
	endproperty
	a_word_only: assert property (p_word_only) else $error("exception without match");

	property p_low_bits_free;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(FETCH_I.valid && bp_reg[IAB_CHECK_ON_POS] && FETCH_I.addr[31:2] == bp_reg[31:2]
			&& FETCH_I.addr[1:0] != bp_reg[1:0]
			&& FETCH_I.machine_state_instr_translate == bp_reg[IAB_XLATE_POS])
		|=> BKPT_EXC_O;
	endproperty
	a_low_bits_free: assert property (p_low_bits_free) else $error("low bits took part");

	property p_xlate;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		BKPT_EXC_O |-> $past(FETCH_I.machine_state_instr_translate) == $past(bp_reg[IAB_XLATE_POS]);
	endproperty
	a_xlate: assert property (p_xlate) else $error("translation state mismatch on hit");

	property p_addr_reported;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		BKPT_EXC_O |-> BKPT_ADDR_O == $past(FETCH_I.addr);
	endproperty
	a_addr_reported: assert property (p_addr_reported) else $error("wrong faulting address");

	// The core reads address and vector late, so both must hold between hits
	property p_addr_held;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		!BKPT_EXC_O |-> ($stable(BKPT_ADDR_O) && $stable(BKPT_VECTOR_O));
	endproperty
	a_addr_held: assert property (p_addr_held) else $error("address moved without hit");

	property p_vector;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		BKPT_EXC_O |-> BKPT_VECTOR_O == IAB_EXC_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("wrong exception vector");

	// No fetch means nothing to break on, whatever the bus shows
	property p_idle_quiet;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		!FETCH_I.valid |=> !BKPT_EXC_O;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("exception without fetch");

	// Checks on the register port
	property p_sup_write;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(SREG_REQ_I.wr && SREG_REQ_I.num == IAB_SREG_NUM && SUPERVISOR_I)
		|=> bp_reg == $past(SREG_REQ_I.wdata);
	endproperty
	a_sup_write: assert property (p_sup_write) else $error("supervisor write not stored");

	property p_user_blocked;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(SREG_REQ_I.wr && SREG_REQ_I.num == IAB_SREG_NUM && !SUPERVISOR_I)
		|=> ($stable(bp_reg) && SREG_PRIV_FAULT_O);
	endproperty
	a_user_blocked: assert property (p_user_blocked) else $error("user write not refused");

	// A user read must leak nothing: no valid pulse, old data left in place
	property p_user_read;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(SREG_REQ_I.rd && SREG_REQ_I.num == IAB_SREG_NUM && !SUPERVISOR_I)
		|=> (!SREG_RD_VALID_O && SREG_PRIV_FAULT_O && $stable(SREG_RDATA_O));
	endproperty
	a_user_read: assert property (p_user_read) else $error("user read answered");

	property p_sup_no_fault;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		SUPERVISOR_I |=> !SREG_PRIV_FAULT_O;
	endproperty
	a_sup_no_fault: assert property (p_sup_no_fault) else $error("fault as supervisor");

	// Other numbers belong to other registers and must leave this one alone
	property p_other_num;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(SREG_REQ_I.wr && SREG_REQ_I.num != IAB_SREG_NUM)
		|=> $stable(bp_reg);
	endproperty
	a_other_num: assert property (p_other_num) else $error("other number stored");

	property p_read_back;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		(SREG_REQ_I.rd && SREG_REQ_I.num == IAB_SREG_NUM && SUPERVISOR_I)
		|=> (SREG_RD_VALID_O && SREG_RDATA_O == $past(bp_reg));
	endproperty
	a_read_back: assert property (p_read_back) else $error("read returned wrong value");

	property p_rdata_held;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		!SREG_RD_VALID_O |-> $stable(SREG_RDATA_O);
	endproperty
	a_rdata_held: assert property (p_rdata_held) else $error("read data moved");

	// Checks on the enable bit
	property p_disabled_quiet;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		!bp_reg[IAB_CHECK_ON_POS] |=> !BKPT_EXC_O;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("exception while disabled");

	property p_enable_seen;
		@(posedge MCLK_I) disable iff (!RESET_N_I)
		BKPT_EXC_O |-> $past(bp_reg[IAB_CHECK_ON_POS]);
	endproperty
	a_enable_seen: assert property (p_enable_seen) else $error("enable was clear");

endmodule : iab_breakpoint

// ---- verification/iab_fetch_model.sv ----
// Partner model: core fetch stage feeding the breakpoint unit
`timescale 1ns/1ps
module iab_fetch_model import iab_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Fetch request from the bench
	input wire iab_fetch_t req_i,
	// Fetch bus to the unit
	output iab_fetch_t fetch_o
);
	logic [31:0] last_reg = 32'h0;
	logic xl_reg = 1'b0;
	// Idle bus shows the inverted last address and a toggling translate bit, so a stuck compare cannot hide
	always @(posedge clk_i) begin
		if (req_i.valid) begin
			last_reg <= req_i.addr;
		end
		xl_reg <= ~xl_reg;
	end
	assign fetch_o = req_i.valid ? req_i : '{1'b0, ~last_reg, xl_reg};
endmodule : iab_fetch_model

// ---- verification/iab_breakpoint_tb_top.sv ----
// Self-checking bench for the breakpoint unit
`timescale 1ns/1ps
module iab_breakpoint_tb_top import iab_pkg::*; ;
	logic MCLK_I = 0;
	logic RESET_N_I = 0;
	logic sup = 0;
	iab_sreg_req_t sreg_req = '0;
	iab_fetch_t fq_req = '0;
	iab_fetch_t fetch;
	logic [31:0] rdata, bvec, baddr;
	logic [31:0] bp = IAB_REG_RESET;
	logic rvalid, pfault, bexc;
	logic [31:0] eq[$];
	logic [31:0] rq[$];
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int fault_due = 0;

	always #2 MCLK_I = ~MCLK_I;

	iab_breakpoint u_dut (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .SREG_REQ_I(sreg_req),
		.SUPERVISOR_I(sup), .SREG_RDATA_O(rdata), .SREG_RD_VALID_O(rvalid),
		.SREG_PRIV_FAULT_O(pfault), .FETCH_I(fetch), .BKPT_EXC_O(bexc),
		.BKPT_VECTOR_O(bvec), .BKPT_ADDR_O(baddr));
	iab_fetch_model u_far (.clk_i(MCLK_I), .req_i(fq_req), .fetch_o(fetch));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task end_sim;
		chk(32'(eq.size() + rq.size() + fault_due), 32'h0);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	// One register access, then an idle cycle; old value read before write lands
	task sreg_acc(input logic w, input logic r, input logic s, input logic [9:0] n,
		input logic [31:0] d);
		sreg_req = '{w, r, n, d};
		sup = s;
		if (n == IAB_SREG_NUM && !s && (w || r)) fault_due++;
		if (n == IAB_SREG_NUM && s && r) rq.push_back(bp);
		if (n == IAB_SREG_NUM && s && w) bp = d;
		@(posedge MCLK_I);
		#1 sreg_req = '0;
		@(posedge MCLK_I);
		#1;
	endtask : sreg_acc

	// One fetch per cycle; expected hit from the stored word
	task ft(input logic [31:0] a, input logic x);
		fq_req = '{1'b1, a, x};
		if (bp[1] && a[31:2] == bp[31:2] && bp[0] == x) eq.push_back(a);
		@(posedge MCLK_I);
		#1;
	endtask : ft

	// Watcher: checks outputs 2 ns after the edge, once they have settled
	always @(posedge MCLK_I) begin
		#2;
		if (RESET_N_I && bexc === 1'b1) begin
			chk(32'(eq.size() > 0), 32'h1);
			if (eq.size() > 0) chk(baddr, eq.pop_front());
			chk(bvec, IAB_EXC_VECTOR);
		end
		if (RESET_N_I && rvalid === 1'b1) begin
			chk(32'(rq.size() > 0), 32'h1);
			if (rq.size() > 0) chk(rdata, rq.pop_front());
		end
		if (RESET_N_I && pfault === 1'b1) begin
			chk(32'(fault_due > 0), 32'h1);
			fault_due--;
		end
	end

	// Hang guard, far above the few hundred cycles needed
	always @(posedge MCLK_I) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		void'($urandom(90594));
		repeat (4) @(posedge MCLK_I);
		#1 RESET_N_I = 1;
		sreg_acc(0, 1, 1, IAB_SREG_NUM, 32'h0);
		sreg_acc(1, 0, 0, IAB_SREG_NUM, 32'hffff_ffff);
		sreg_acc(0, 1, 0, IAB_SREG_NUM, 32'h0);
		sreg_acc(1, 0, 1, IAB_SREG_NUM + 10'h1, 32'hffff_ffff);
		sreg_acc(1, 1, 1, IAB_SREG_NUM, 32'h0000_1003);
		sreg_acc(0, 1, 1, IAB_SREG_NUM, 32'h0);
		// Low bits ignored, translation bit must agree, neighbours miss
		ft(32'h0000_1000, 1);
		ft(32'h0000_1003, 1);
		ft(32'h0000_1000, 0);
		ft(32'h0000_1004, 1);
		ft(32'h0000_0ffc, 1);
		ft(32'h0000_1001, 1);
		fq_req = '0;
		repeat (30) begin
			sreg_acc(1, 0, 1, IAB_SREG_NUM, $urandom);
			for (int i = 0; i < 8; i++) begin
				ft({bp[31:2] ^ 30'($urandom_range(0, 1) ? 0 : $urandom), 2'($urandom)},
					1'($urandom));
			end
			fq_req = '0;
		end
		repeat (3) @(posedge MCLK_I);
		end_sim();
	end
endmodule : iab_breakpoint_tb_top
